// ===== common/scsc_pkg.sv
// Constants and carrier types of the serial control slave
package scsc_pkg;
    // ------------------------------------------------------------
    // Register offsets, reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_RST = 8'h01;
    localparam logic [7:0] OFF_CFG = 8'h03;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] RST_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hD2;
    localparam logic [7:0] CFG_MASK = 8'hBB;
    localparam logic [7:0] RST_MASK = 8'h80;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ADDR_SEL_BIT = 0;
    localparam int PD_BIT = 7;
    localparam int FULL_RST_BIT = 1;
    localparam int LOGIC_RST_BIT = 0;
    localparam int CRC_BIT = 7;
    localparam int FILT_BIT = 4;
    localparam int AUTO_OSC_BIT = 1;
    localparam int EDGE_BIT = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int PCLK_LOSS_NS = 1000;
    localparam logic [7:0] PCLK_LOSS_CYC = 8'(PCLK_LOSS_NS / CLK_NS);
    localparam logic [2:0] PIX_RST_CYC = 3'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic pixel_valid;
        logic line_sync;
        logic frame_sync;
    } scsc_video_t;
    typedef struct packed {
        logic filt_en;
        logic rise_edge;
    } scsc_pix_cfg_t;
endpackage

// ===== design/scsc_sync.sv
// Two-flop level synchroniser
module scsc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule

// ===== design/scsc_pix_capture.sv
// Pixel clock domain: input capture, short pulse filter, clock beacon
module scsc_pix_capture (
    input wire logic pclk_i,
    input wire logic rst_i,
    input scsc_pkg::scsc_pix_cfg_t cfg_i,
    input scsc_pkg::scsc_video_t vid_i,
    output scsc_pkg::scsc_video_t vid_o,
    output logic tgl_o
);
    import scsc_pkg::*;

    logic [2:0] cs_w;
    logic rst_s;
    logic filt_s;
    logic rise_s;
    logic [2:0] cap_r_reg;
    logic [2:0] cap_f_reg;
    logic [2:0] smp_reg, smp_next;
    logic [2:0] hist_reg, hist_next;
    logic [2:0] out_reg, out_next;
    logic tgl_reg, tgl_next;

    scsc_sync #(.W(3)) u_cfg_sync (
        .clk_i(pclk_i),
        .rst_i(1'b0),
        .d_i({rst_i, cfg_i.filt_en, cfg_i.rise_edge}),
        .q_o(cs_w)
    );
    assign rst_s = cs_w[2];
    assign filt_s = cs_w[1];
    assign rise_s = cs_w[0];

    // (R16) capture edge choice
    always_ff @(posedge pclk_i) begin
        cap_r_reg <= vid_i;
    end
    always_ff @(negedge pclk_i) begin
        cap_f_reg <= vid_i;
    end

    always_comb begin
        smp_next = rise_s ? cap_r_reg : cap_f_reg;
        hist_next = smp_reg;
        tgl_next = ~tgl_reg;
        // (R14) two-cycle pulse filter
        if (filt_s) begin
            out_next = (~(smp_reg ^ hist_reg) & smp_reg) | ((smp_reg ^ hist_reg) & out_reg);
        end else begin
            out_next = smp_reg;
        end
    end

    always_ff @(posedge pclk_i) begin
        if (rst_s) begin
            smp_reg <= '0;
            hist_reg <= '0;
            out_reg <= '0;
            tgl_reg <= 1'b0;
        end else begin
            smp_reg <= smp_next;
            hist_reg <= hist_next;
            out_reg <= out_next;
            tgl_reg <= tgl_next;
        end
    end

    assign vid_o = out_reg;
    assign tgl_o = tgl_reg;
endmodule

// ===== design/scsc_serial_slave.sv
// Serial control slave with its configuration registers
// ------------------------------------------------------------
// What this block does
// (R1) Start and stop framed on clock-high data edges
// (R2) Acknowledge a matching slave address
// (R3) Release data line on address mismatch
// (R4) Acknowledge every written data byte
// (R5) Master acknowledges to get another byte
// (R6) Master ends read with NACK, stop
// (R7) Transfers open on start, close on stop
// (R8) Writable 7-bit address in bits 7:1
// (R9) Bit 0 picks register or strap address
// (R10) Auto power down without control link
// (R11) Self-clearing full reset including registers
// (R12) Self-clearing logic reset keeping registers
// (R13) Back-channel check enable, reset value D2 (register loads D2 & BB = 92, reserved bit 6 cleared)
// (R14) Filter sub-two-cycle pulses on sync inputs
// (R15) Internal oscillator when pixel clock absent
// (R16) Select pixel capture clock edge
// (R17) Reserved bits read zero, writes ignored
// ------------------------------------------------------------
module scsc_serial_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [6:0] address_strap_pin_i,
    input wire logic link_detect_i,
    input wire logic pclk_i,
    input scsc_pkg::scsc_video_t vid_i,
    output scsc_pkg::scsc_video_t vid_o,
    output logic power_down_o,
    output logic osc_select_o,
    output logic crc_check_en_o
);
    import scsc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } scsc_state_t;

    // ------------------------------------------------------------
    // Pin synchronisers and bus events
    // ------------------------------------------------------------
    logic [10:0] sync_w;
    logic scl_s, sda_s, tgl_s, link_s;
    logic [6:0] strap_s;
    logic pix_tgl_w;
    logic scl_d_reg, scl_d_next;
    logic sda_d_reg, sda_d_next;
    logic rise_w, fall_w, start_w, stop_w;

    scsc_sync #(.W(11)) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(sys_rst_i),
        .d_i({scl_i, sda_i, pix_tgl_w, link_detect_i, address_strap_pin_i}),
        .q_o(sync_w)
    );
    assign scl_s = sync_w[10];
    assign sda_s = sync_w[9];
    assign tgl_s = sync_w[8];
    assign link_s = sync_w[7];
    assign strap_s = sync_w[6:0];

    assign rise_w = scl_s & ~scl_d_reg;
    assign fall_w = ~scl_s & scl_d_reg;
    // (R1) start and stop detection
    assign start_w = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_w = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] addr_reg, addr_next;
    logic pd_en_reg, pd_en_next;
    logic [7:0] cfg_reg, cfg_next;
    logic full_rst_reg, full_rst_next;
    logic logic_rst_reg, logic_rst_next;
    logic rrst_w, lrst_w;
    logic wr_stb;
    logic [7:0] ptr_reg, ptr_next;
    logic [7:0] shift_reg, shift_next;
    logic [6:0] my_addr_w;

    assign rrst_w = sys_rst_i | full_rst_reg;
    assign lrst_w = rrst_w | logic_rst_reg;
    // (R9) address source select
    assign my_addr_w = addr_reg[ADDR_SEL_BIT] ? addr_reg[7:1] : strap_s;

    // Read view; reset bits always read zero
    function automatic logic [7:0] reg_read(input logic [7:0] p);
        logic [7:0] v;
        v = 8'h00;
        case (p)
            OFF_ADDR: v = addr_reg;
            OFF_RST: v = {pd_en_reg, 7'h00};
            OFF_CFG: v = cfg_reg & CFG_MASK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        addr_next = addr_reg;
        pd_en_next = pd_en_reg;
        cfg_next = cfg_reg;
        if (wr_stb) begin
            case (ptr_reg)
                // (R8) address register write
                OFF_ADDR: addr_next = shift_reg;
                OFF_RST: pd_en_next = shift_reg[PD_BIT];
                // (R17) reserved bits masked
                OFF_CFG: cfg_next = shift_reg & CFG_MASK;
                default: addr_next = addr_reg;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rrst_w) begin
            addr_reg <= ADDR_RST;
            pd_en_reg <= RST_RST[PD_BIT];
            // (R13) configuration reset value
            cfg_reg <= CFG_RST & CFG_MASK;
        end else begin
            addr_reg <= addr_next;
            pd_en_reg <= pd_en_next;
            cfg_reg <= cfg_next;
        end
    end

    // ------------------------------------------------------------
    // Soft resets, deferred to the end of the frame
    // ------------------------------------------------------------
    logic full_pend_reg, full_pend_next;
    logic logic_pend_reg, logic_pend_next;
    logic [2:0] prc_reg, prc_next;
    logic pix_rst_reg, pix_rst_next;
    scsc_state_t state_reg, state_next;

    always_comb begin
        full_pend_next = full_pend_reg;
        logic_pend_next = logic_pend_reg;
        full_rst_next = 1'b0;
        logic_rst_next = 1'b0;
        // (R11) full reset pulse, self-clearing
        // (R12) logic reset pulse, self-clearing
        if (state_reg == ST_IDLE && (full_pend_reg || logic_pend_reg)) begin
            full_rst_next = full_pend_reg;
            logic_rst_next = ~full_pend_reg;
            full_pend_next = 1'b0;
            logic_pend_next = 1'b0;
        end
        if (wr_stb && ptr_reg == OFF_RST) begin
            full_pend_next = full_pend_next | shift_reg[FULL_RST_BIT];
            logic_pend_next = logic_pend_next | shift_reg[LOGIC_RST_BIT];
        end
        if (lrst_w) begin
            prc_next = PIX_RST_CYC;
        end else if (prc_reg != 3'h0) begin
            prc_next = prc_reg - 3'h1;
        end else begin
            prc_next = 3'h0;
        end
        pix_rst_next = prc_next != 3'h0;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            full_pend_reg <= 1'b0;
            logic_pend_reg <= 1'b0;
            full_rst_reg <= 1'b0;
            logic_rst_reg <= 1'b0;
            prc_reg <= PIX_RST_CYC;
            pix_rst_reg <= 1'b1;
        end else begin
            full_pend_reg <= full_pend_next;
            logic_pend_reg <= logic_pend_next;
            full_rst_reg <= full_rst_next;
            logic_rst_reg <= logic_rst_next;
            prc_reg <= prc_next;
            pix_rst_reg <= pix_rst_next;
        end
    end

    // ------------------------------------------------------------
    // Bus slave state machine
    // ------------------------------------------------------------
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] tx_reg, tx_next;
    logic rw_reg, rw_next;
    logic mack_reg, mack_next;
    logic oe_reg, oe_next;
    logic [7:0] ptr_inc_w;

    assign ptr_inc_w = ptr_reg + 8'h01;

    always_comb begin
        logic [7:0] rd_byte;
        rd_byte = reg_read(ptr_reg);
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        mack_next = mack_reg;
        oe_next = oe_reg;
        wr_stb = 1'b0;
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        // (R7) frame opens on start, closes on stop
        if (start_w) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_w) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: oe_next = 1'b0;
                ST_ADDR, ST_REG, ST_WR: begin
                    if (rise_w && cnt_reg != BYTE_BITS) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (fall_w && cnt_reg == BYTE_BITS) begin
                        cnt_next = 4'h0;
                        if (state_reg == ST_ADDR) begin
                            // (R2) acknowledge matching address
                            if (shift_reg[7:1] == my_addr_w) begin
                                oe_next = 1'b1;
                                rw_next = shift_reg[0];
                                state_next = ST_ADDR_ACK;
                            // (R3) mismatch leaves the line released
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_REG) begin
                            ptr_next = shift_reg;
                            oe_next = 1'b1;
                            state_next = ST_REG_ACK;
                        end else begin
                            // (R4) acknowledge each written byte
                            wr_stb = 1'b1;
                            oe_next = 1'b1;
                            state_next = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (fall_w && rw_reg) begin
                        tx_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        cnt_next = 4'h1;
                        state_next = ST_RD;
                    end else if (fall_w) begin
                        oe_next = 1'b0;
                        state_next = ST_REG;
                    end
                end
                ST_REG_ACK, ST_WR_ACK: begin
                    if (fall_w) begin
                        oe_next = 1'b0;
                        state_next = ST_WR;
                        if (state_reg == ST_WR_ACK) begin
                            ptr_next = ptr_inc_w;
                        end
                    end
                end
                ST_RD: begin
                    if (fall_w && cnt_reg == BYTE_BITS) begin
                        oe_next = 1'b0;
                        state_next = ST_RD_ACK;
                    end else if (fall_w) begin
                        oe_next = ~tx_reg[6];
                        tx_next = {tx_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                ST_RD_ACK: begin
                    // (R5) master acknowledge asks for more
                    if (rise_w) begin
                        mack_next = ~sda_s;
                    end else if (fall_w && mack_reg) begin
                        ptr_next = ptr_inc_w;
                        tx_next = reg_read(ptr_inc_w);
                        oe_next = ~tx_next[7];
                        cnt_next = 4'h1;
                        state_next = ST_RD;
                    // (R6) NACK ends the read
                    end else if (fall_w) begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (lrst_w) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            mack_reg <= mack_next;
            oe_reg <= oe_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // ------------------------------------------------------------
    // Pixel clock watch and power control
    // ------------------------------------------------------------
    logic tgl_d_reg, tgl_d_next;
    logic [7:0] miss_reg, miss_next;
    logic osc_reg, osc_next;
    logic pd_reg, pd_next;

    always_comb begin
        tgl_d_next = tgl_s;
        if (tgl_s != tgl_d_reg) begin
            miss_next = 8'h00;
        end else if (miss_reg != PCLK_LOSS_CYC) begin
            miss_next = miss_reg + 8'h01;
        end else begin
            miss_next = miss_reg;
        end
        // (R15) oscillator switch-over
        osc_next = cfg_reg[AUTO_OSC_BIT] && miss_reg == PCLK_LOSS_CYC;
        // (R10) remote auto power down
        pd_next = pd_en_reg && !link_s;
    end

    always_ff @(posedge clk_i) begin
        if (lrst_w) begin
            tgl_d_reg <= 1'b0;
            miss_reg <= 8'h00;
            osc_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            tgl_d_reg <= tgl_d_next;
            miss_reg <= miss_next;
            osc_reg <= osc_next;
            pd_reg <= pd_next;
        end
    end

    scsc_pix_capture u_pix (
        .pclk_i(pclk_i),
        .rst_i(pix_rst_reg),
        .cfg_i({cfg_reg[FILT_BIT], cfg_reg[EDGE_BIT]}),
        .vid_i(vid_i),
        .vid_o(vid_o),
        .tgl_o(pix_tgl_w)
    );

    // Open-drain data line: only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign power_down_o = pd_reg;
    assign osc_select_o = osc_reg;
    // (R13) back-channel check enable
    assign crc_check_en_o = cfg_reg[CRC_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    start_to_addr_a: assert property (start_w && !lrst_w |=> state_reg == ST_ADDR) // (R1)
        else $error("start not seen");
    addr_ack_a: assert property (state_reg == ST_ADDR && fall_w && cnt_reg == BYTE_BITS // (R2)
        && shift_reg[7:1] == my_addr_w && !start_w && !stop_w && !lrst_w
        |=> oe_reg && state_reg == ST_ADDR_ACK)
        else $error("address not acknowledged");
    addr_nack_a: assert property (state_reg == ST_ADDR && shift_reg[7:1] != my_addr_w // (R3)
        |-> !oe_reg)
        else $error("line driven on mismatch");
    wr_ack_a: assert property (wr_stb && !lrst_w |=> oe_reg && state_reg == ST_WR_ACK) // (R4)
        else $error("write byte not acknowledged");
    stop_idle_a: assert property (stop_w && !start_w && !lrst_w // (R7)
        |=> state_reg == ST_IDLE ##1 !oe_reg)
        else $error("stop did not end frame");
    addr_store_a: assert property (wr_stb && ptr_reg == OFF_ADDR && !lrst_w // (R8)
        |=> addr_reg == $past(shift_reg))
        else $error("address register not written");
    addr_src_a: assert property (!addr_reg[ADDR_SEL_BIT] |-> my_addr_w == strap_s) // (R9)
        else $error("strap address not used");
    power_down_a: assert property (!lrst_w ##1 !lrst_w // (R10)
        |-> power_down_o == $past(pd_en_reg && !link_s))
        else $error("power down wrong");
    full_reset_a: assert property (full_rst_reg // (R11)
        |=> cfg_reg == (CFG_RST & CFG_MASK) && addr_reg == ADDR_RST && !full_rst_reg)
        else $error("full reset failed");
    logic_reset_a: assert property (logic_rst_reg && !full_rst_reg // (R12)
        |=> $stable(cfg_reg) && state_reg == ST_IDLE && !logic_rst_reg)
        else $error("logic reset failed");
    osc_switch_a: assert property (cfg_reg[AUTO_OSC_BIT] && miss_reg == PCLK_LOSS_CYC // (R15)
        && !lrst_w |=> osc_select_o)
        else $error("no oscillator switch");
    reserved_a: assert property ((cfg_reg & ~CFG_MASK) == 8'h00) // (R17)
        else $error("reserved bit set");
endmodule

// ===== verification/scsc_master_model.sv
// Bus master model driving the serial control bus
module scsc_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        hold(5);
        scl_o = 1'b1;
        hold(10);
        sda_low_o = 1'b1;
        hold(10);
        scl_o = 1'b0;
        hold(5);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        hold(5);
        scl_o = 1'b1;
        hold(10);
        sda_low_o = 1'b0;
        hold(10);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_low_o = !b;
        hold(5);
        scl_o = 1'b1;
        hold(5);
        s = sda_i;
        hold(5);
        scl_o = 1'b0;
        hold(5);
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // ack for more, nack the last byte
    task automatic rx(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!more, s);
    endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the serial control slave
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import scsc_pkg::*;
    localparam logic [6:0] STRAP = 7'h0C;
    localparam logic [6:0] NEWA = 7'h2A;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pclk = 1'b0;
    logic pclk_run = 1'b1;
    logic link = 1'b1;
    logic seen = 1'b0;
    logic scl, m_low, sda_o, sda_oe, pd, osc, crc;
    scsc_video_t vid_in = '0;
    scsc_video_t vid_out;
    int fail_count = 0;
    int checks_done = 0;
    wire logic sda = !m_low && !(sda_oe && !sda_o);
    wire logic [1:0] st = {osc, pd};
    always #10 clk_i = ~clk_i;
    always #6 if (pclk_run) pclk = ~pclk;
    always @(posedge pclk) if (vid_out.pixel_valid === 1'b1) seen = 1'b1;
    scsc_serial_slave dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .address_strap_pin_i(STRAP),
        .link_detect_i(link), .pclk_i(pclk), .vid_i(vid_in), .vid_o(vid_out),
        .power_down_o(pd), .osc_select_o(osc), .crc_check_en_o(crc)
    );
    scsc_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic probe(input logic [6:0] a, input logic exp);
        logic k;
        m.start();
        m.tx({a, 1'b0}, k);
        m.stop();
        chk({7'h0, k}, {7'h0, exp});
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d);
        logic k;
        m.start();
        m.tx({a, 1'b0}, k);
        chk({7'h0, k}, 8'h01);
        m.tx(off, k);
        chk({7'h0, k}, 8'h01);
        m.tx(d, k);
        chk({7'h0, k}, 8'h01);
        m.stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] off, input logic [7:0] e0,
                      input logic [7:0] e1, input logic two);
        logic k;
        logic [7:0] d;
        m.start();
        m.tx({a, 1'b0}, k);
        m.tx(off, k);
        m.start();
        m.tx({a, 1'b1}, k);
        chk({7'h0, k}, 8'h01);
        m.rx(two, d);
        chk(d, e0);
        if (two) begin
            m.rx(1'b0, d);
            chk(d, e1);
        end
        m.stop();
    endtask
    task automatic wait_lvl(input int sel, input logic v);
        for (int i = 0; i < 100 && st[sel] !== v; i++) @(negedge clk_i);
        chk({7'h0, st[sel]}, {7'h0, v});
        if (st[sel] !== v) summarize();
    endtask
    task automatic pulse(input int n, input logic exp);
        seen = 1'b0;
        @(negedge pclk) vid_in <= 3'b100;
        repeat (n) @(negedge pclk);
        vid_in <= 3'b000;
        repeat (12) @(negedge pclk);
        chk({7'h0, seen}, {7'h0, exp});
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        chk({7'h0, crc}, 8'h01);
        rd(STRAP, OFF_ADDR, ADDR_RST, RST_RST, 1'b1);
        rd(STRAP, OFF_CFG, CFG_RST & CFG_MASK, 8'h00, 1'b1);
        probe(NEWA, 1'b0);
        $display("reset values done");
        pclk_run = 1'b0;
        wait_lvl(1, 1'b1);
        pclk_run = 1'b1;
        wait_lvl(1, 1'b0);
        pulse(1, 1'b0);
        pulse(2, 1'b1);
        wr(STRAP, OFF_CFG, 8'h7F);
        chk({7'h0, crc}, 8'h00);
        rd(STRAP, OFF_CFG, 8'h7F & CFG_MASK, 8'h00, 1'b0);
        pulse(2, 1'b1);
        pulse(1, 1'b0);
        wr(STRAP, OFF_CFG, 8'h80);
        pulse(1, 1'b1);
        pclk_run = 1'b0;
        repeat (100) @(negedge clk_i);
        chk({7'h0, osc}, 8'h00);
        pclk_run = 1'b1;
        $display("config done");
        wr(STRAP, OFF_ADDR, {NEWA, 1'b1});
        probe(STRAP, 1'b0);
        rd(NEWA, OFF_ADDR, {NEWA, 1'b1}, RST_RST, 1'b1);
        link = 1'b0;
        repeat (10) @(negedge clk_i);
        chk({7'h0, pd}, 8'h00);
        wr(NEWA, OFF_RST, 8'h80);
        wait_lvl(0, 1'b1);
        link = 1'b1;
        wait_lvl(0, 1'b0);
        wr(NEWA, OFF_RST, 8'h81);
        rd(NEWA, OFF_RST, 8'h80, 8'h00, 1'b0);
        wr(NEWA, OFF_RST, 8'h02);
        probe(NEWA, 1'b0);
        rd(STRAP, OFF_RST, RST_RST, 8'h00, 1'b0);
        $display("address and resets done");
        summarize();
    end
endmodule
